/* File: dv/irq_sleep_props.sv */
// assertions on the link and the controller status
// assumes one clock domain; instantiated beside the link
module irq_sleep_props
   import irq_sleep_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // link
   input wire logic [2:0] op,
   input wire logic op_valid,
   input wire logic [15:0] pc,
   input wire logic op_done,
   input wire logic [15:0] next_pc,
   input wire logic irq_pending,
   input wire logic cpu_halted,
   // controller
   input wire logic stack_we,
   input wire logic [7:0] stack_addr,
   input wire logic [15:0] stack_wdata,
   input wire logic [7:0] stack_pointer,
   input wire logic global_enable,
   input wire logic [n_lines-1:0] irq_flags,
   input wire logic [n_lines-1:0] irq_line_enables,
   input wire logic flag_write,
   input wire logic [n_lines-1:0] flag_write_data,
   input wire logic system_clock_en,
   input wire logic fast_internal_osc_en,
   input wire logic slow_internal_osc_en,
   input wire logic crystal_osc_en,
   input wire logic program_mem_on
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic take, reti, nap, deep;
   assign take = op_valid && op == op_take_irq;
   assign reti = op_valid && op == op_reti;
   assign nap = op_valid && op == op_light_sleep;
   assign deep = op_valid && op == op_deep_sleep;
   ////////////////////////////////////////////////////////////
   a_take_push: assert property (take |=> stack_we && stack_addr == $past(stack_pointer)
      && stack_wdata == $past(pc) && stack_pointer == $past(stack_pointer) + 8'h02)
      else $error("entry push wrong");
   a_take_vector: assert property (take |=> op_done && next_pc == vector_addr
      && !global_enable) else $error("entry vector wrong");
   a_reti_pop: assert property (reti |=> !op_done ##1 op_done && global_enable
      && stack_pointer == $past(stack_pointer, 2) - 8'h02) else $error("return wrong");
   a_pending_cause: assert property (irq_pending |-> $past(global_enable)
      && $past(|(irq_flags & irq_line_enables))) else $error("pending without cause");
   // a one-edge reset may drop flags, so the edge after it is skipped
   a_flag_clear: assert property (!$past(reset) && |($past(irq_flags) & ~irq_flags)
      |-> $past(flag_write) && !(|($past(irq_flags) & ~irq_flags & $past(flag_write_data))))
      else $error("flag dropped without zero write");
   a_nap_halt: assert property (nap |-> ##2 cpu_halted && !system_clock_en
      && slow_internal_osc_en) else $error("light sleep gating wrong");
   a_deep_stop: assert property (deep |-> ##[2:3] !fast_internal_osc_en
      && !slow_internal_osc_en && !crystal_osc_en) else $error("deep sleep osc on");
   a_mem_off: assert property (nap || deep |-> ##[1:2] !program_mem_on)
      else $error("program memory left on");
endmodule // irq_sleep_props

/* File: dv/tb_top.sv */
// bench: controller and core end on one link, driven from both user sides
// assumes a slow tick every clock and a stack ram with combinational read
module tb_top
   import irq_sleep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
   int n_tests = 0, fail_count = 0, lat, seed, r;
   logic clk_sys = 1'b0, reset = 1'b1, flag_write = 1'b0, fast_boot = 1'b0, req = 1'b0;
   logic global_enable_op = 1'b0, global_disable_op = 1'b0, stack_pointer_write = 1'b0;
   logic comparator_event = 1'b0, slow_osc_tick = 1'b1;
   logic [7:0] irq_line_enables = '0, flag_write_data = '0, stack_pointer_wdata = '0;
   logic [7:0] comparator_control = '0, comparator_select = '0, system_option = '0;
   logic [7:0] irq_sources = '0, req_work = '0, req_flags = '0, prev, sp0, wk, fl;
   logic [15:0] edge_select = '0, pins_in = '0, pin_direction = 16'h00ff, req_pc = '0;
   logic [15:0] pin_digital_enable = 16'h0f0f, pc0;
   logic [2:0] timer_match = '0, timer_off_system_clock = 3'h1, req_op = '0;
   logic [15:0] stack_mem [256];
   logic stack_we, ack, irq_seen, halted, global_enable, system_clock_en, system_clock_timer_run;
   logic fast_internal_osc_en, slow_internal_osc_en, crystal_osc_en, program_mem_on;
   logic run_on_slow_osc;
   logic [7:0] stack_addr, irq_flags, stack_pointer, work_out, flags_out;
   logic [15:0] stack_wdata, resume_pc, stack_rdata;
   irq_sleep_if link ();
   irq_sleep_ctrl u_irq_sleep_ctrl (.clk_sys, .reset, .core(link), .irq_line_enables,
      .edge_select, .flag_write, .flag_write_data, .global_enable_op, .global_disable_op,
      .stack_pointer_wdata, .stack_pointer_write, .comparator_control, .comparator_select,
      .system_option, .fast_boot, .irq_sources, .pins_in, .pin_direction,
      .pin_digital_enable, .timer_match, .timer_off_system_clock, .comparator_event,
      .slow_osc_tick, .stack_we, .stack_addr, .stack_wdata, .stack_rdata, .irq_flags,
      .stack_pointer, .global_enable, .system_clock_en, .fast_internal_osc_en,
      .slow_internal_osc_en, .crystal_osc_en, .program_mem_on, .system_clock_timer_run,
      .run_on_slow_osc);
   core_stack_end u_core_stack_end (.clk_sys, .reset, .link, .req, .req_op, .req_pc,
      .req_work, .req_flags, .ack, .resume_pc, .work_out, .flags_out, .irq_seen, .halted);
   irq_sleep_props u_irq_sleep_props (.clk_sys, .reset, .op(link.op),
      .op_valid(link.op_valid), .pc(link.pc), .op_done(link.op_done),
      .next_pc(link.next_pc), .irq_pending(link.irq_pending), .cpu_halted(link.cpu_halted),
      .stack_we, .stack_addr, .stack_wdata, .stack_pointer, .global_enable, .irq_flags,
      .irq_line_enables, .flag_write, .flag_write_data, .system_clock_en,
      .fast_internal_osc_en, .slow_internal_osc_en, .crystal_osc_en, .program_mem_on);
   ////////////////////////////////////////////////////////////
   // combinational read: the popped word is there whichever edge samples it
   assign stack_rdata = stack_mem[stack_addr];
   always @(posedge clk_sys) begin
      if (stack_we)
         stack_mem[stack_addr] <= stack_wdata;
   end
   always #2 clk_sys = ~clk_sys;
   function automatic logic flag_exp(input logic [1:0] m, input logic rise);
      return rise ? m != edge_fall : m != edge_rise;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic run_op(input logic [2:0] o, input logic [15:0] p);
      @(negedge clk_sys);
      req = 1'b1;
      req_op = o;
      req_pc = p;
      req_work = 8'($random(seed));
      req_flags = 8'($random(seed));
      if (o == op_light_sleep || o == op_deep_sleep)
         return;
      await();
   endtask
   task automatic await();
      lat = 0;
      // ack is looked at mid-cycle, where it stands settled
      do begin
         @(negedge clk_sys);
         lat++;
      end while (ack !== 1'b1 && lat < 5000);
      `CHK(ack, 1'b1)
      req = 1'b0;
   endtask
   task automatic go_sleep(input logic [2:0] o, input logic dp);
      timer_match = '0;
      comparator_event = 1'b0;
      pc0 = 16'($random(seed));
      r = $random(seed) & 3;
      run_op(o, pc0);
      cyc(10);
      `CHK(halted, 1'b1)
      `CHK(system_clock_en, 1'b0)
      `CHK(program_mem_on, 1'b0)
      `CHK(system_clock_timer_run, 1'b0)
      `CHK(fast_internal_osc_en, ~dp)
      `CHK(slow_internal_osc_en, ~dp)
   endtask
   task automatic wake_done(input int lo, input int hi);
      await();
      `CHK(1'(lat >= lo && lat <= hi), 1'b1)
      `CHK(resume_pc, pc0)
      `CHK(run_on_slow_osc, 1'b1)
      `CHK(system_clock_en, 1'b1)
      `CHK(fast_internal_osc_en, 1'b1)
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      finish_test();
   end
   initial begin
      seed = 32'hd312;
      pins_in = 16'($random(seed));
      for (int i = 0; i < n_lines; i++)
         edge_select[2*i +: 2] = 2'(i % 4);
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      cyc(1);
      // enables stay low: flags must still set
      for (int i = 0; i < n_lines; i++) begin
         prev = irq_flags;
         irq_sources[i] = 1'b1;
         cyc(6);
         `CHK(irq_flags[i], flag_exp(edge_select[2*i +: 2], 1'b1))
         flag_write_data = ~(8'h01 << i);
         flag_write = 1'b1;
         cyc(1);
         flag_write = 1'b0;
         cyc(2);
         `CHK(irq_flags, prev)
         irq_sources[i] = 1'b0;
         cyc(6);
         `CHK(irq_flags[i], flag_exp(edge_select[2*i +: 2], 1'b0))
      end
      `CHK(irq_flags, 8'hee)
      irq_line_enables = 8'h11;
      global_enable_op = 1'b1;
      cyc(1);
      global_enable_op = 1'b0;
      cyc(4);
      `CHK(irq_seen, 1'b0)
      irq_line_enables = 8'h31;
      cyc(4);
      `CHK(irq_seen, 1'b1)
      global_disable_op = 1'b1;
      cyc(1);
      global_disable_op = 1'b0;
      cyc(4);
      `CHK(irq_seen, 1'b0)
      stack_pointer_wdata = 8'($random(seed)) & 8'h7c;
      stack_pointer_write = 1'b1;
      cyc(1);
      stack_pointer_write = 1'b0;
      sp0 = stack_pointer_wdata;
      pc0 = 16'($random(seed));
      run_op(op_take_irq, pc0);
      `CHK(resume_pc, vector_addr)
      `CHK(stack_pointer, sp0 + 8'h02)
      run_op(op_push, pc0);
      wk = req_work;
      fl = req_flags;
      `CHK(stack_pointer, sp0 + 8'h04)
      run_op(op_pop, pc0);
      `CHK({work_out, flags_out}, {wk, fl})
      `CHK(global_enable, 1'b0)
      run_op(op_reti, 16'h0000);
      `CHK(resume_pc, pc0)
      `CHK(stack_pointer, sp0)
      `CHK(global_enable, 1'b1)
      // light sleep: pins lacking either enable, a lone comparator enable and a
      // system-clock timer must all leave it asleep
      system_option = 8'h20;
      go_sleep(op_light_sleep, 1'b0);
      pins_in[4 + r] = ~pins_in[4 + r];
      pins_in[8 + r] = ~pins_in[8 + r];
      comparator_control = 8'h80;
      comparator_event = 1'b1;
      timer_match[1] = 1'b1;
      cyc(12);
      `CHK(halted, 1'b1)
      pins_in[r] = ~pins_in[r];
      wake_done(45, 60);
      system_option = 8'h00;
      fast_boot = 1'b1;
      go_sleep(op_light_sleep, 1'b0);
      timer_match[0] = 1'b1;
      wake_done(45, 60);
      fast_boot = 1'b0;
      comparator_select = 8'h40;
      go_sleep(op_light_sleep, 1'b0);
      comparator_event = 1'b1;
      wake_done(3000, 3015);
      system_option = 8'h20;
      comparator_control = 8'h00;
      go_sleep(op_deep_sleep, 1'b1);
      timer_match[0] = 1'b1;
      pins_in[4 + r] = ~pins_in[4 + r];
      cyc(12);
      `CHK(halted, 1'b1)
      pins_in[8 + r] = ~pins_in[8 + r];
      wake_done(45, 60);
      `CHK(irq_flags, 8'hee)
      `CHK(stack_pointer, sp0)
      finish_test();
   end
endmodule // tb_top

/* File: src/core_stack_end.sv */
// core-side end: issues one stack or sleep operation at a time and waits for done
// assumes user logic holds req until ack
module core_stack_end
   import irq_sleep_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // link
   irq_sleep_if.core link,
   // user side
   input wire logic req,
   input wire logic [2:0] req_op,
   input wire logic [15:0] req_pc,
   input wire logic [7:0] req_work,
   input wire logic [7:0] req_flags,
   output logic ack,
   output logic [15:0] resume_pc,
   output logic [7:0] work_out,
   output logic [7:0] flags_out,
   output logic irq_seen,
   output logic halted
);
   logic busy_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         busy_q <= 1'b0;
         link.op_valid <= 1'b0;
         link.op <= op_none;
         link.pc <= 16'h0000;
         link.work_register <= 8'h00;
         link.flags <= 8'h00;
         ack <= 1'b0;
         resume_pc <= 16'h0000;
         work_out <= 8'h00;
         flags_out <= 8'h00;
      end else begin
         link.op_valid <= 1'b0;
         ack <= 1'b0;
         if (!busy_q && req && !ack) begin
            busy_q <= 1'b1;
            link.op_valid <= 1'b1;
            link.op <= req_op;
            link.pc <= req_pc;
            link.work_register <= req_work;
            link.flags <= req_flags;
         end else if (busy_q && link.op_done) begin
            busy_q <= 1'b0;
            ack <= 1'b1;
            resume_pc <= link.next_pc;
            work_out <= link.work_restore;
            flags_out <= link.flags_restore;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_seen <= 1'b0;
         halted <= 1'b0;
      end else begin
         irq_seen <= link.irq_pending;
         halted <= link.cpu_halted;
      end
   end
endmodule // core_stack_end

/* File: src/irq_sleep_ctrl.sv */
// device end: request flags, stack sequencing, sleep modes and wake-up
// assumes pin and peripheral inputs are asynchronous; stack ram sits in the core's data memory
module irq_sleep_ctrl
   import irq_sleep_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // core side
   irq_sleep_if.device core,
   // software-visible controls
   input wire logic [n_lines-1:0] irq_line_enables,
   input wire logic [2*n_lines-1:0] edge_select,
   input wire logic flag_write,
   input wire logic [n_lines-1:0] flag_write_data,
   input wire logic global_enable_op,
   input wire logic global_disable_op,
   input wire logic [7:0] stack_pointer_wdata,
   input wire logic stack_pointer_write,
   input wire logic [7:0] comparator_control,
   input wire logic [7:0] comparator_select,
   input wire logic [7:0] system_option,
   input wire logic fast_boot,
   // event sources and pins
   input wire logic [n_lines-1:0] irq_sources,
   input wire logic [n_pins-1:0] pins_in,
   input wire logic [n_pins-1:0] pin_direction,
   input wire logic [n_pins-1:0] pin_digital_enable,
   input wire logic [2:0] timer_match,
   input wire logic [2:0] timer_off_system_clock,
   input wire logic comparator_event,
   input wire logic slow_osc_tick,
   // stack memory port
   output logic stack_we,
   output logic [7:0] stack_addr,
   output logic [15:0] stack_wdata,
   input wire logic [15:0] stack_rdata,
   // status and power controls
   output logic [n_lines-1:0] irq_flags,
   output logic [7:0] stack_pointer,
   output logic global_enable,
   output logic system_clock_en,
   output logic fast_internal_osc_en,
   output logic slow_internal_osc_en,
   output logic crystal_osc_en,
   output logic program_mem_on,
   output logic system_clock_timer_run,
   output logic run_on_slow_osc
);
   typedef enum {st_run, st_pop_wait, st_light, st_deep, st_waking} state_t;
   state_t state_q;
   logic wake_done;

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers, edge detect compares the second stage with a third flop
   logic [n_lines-1:0] src_s1_q, src_s2_q, src_prev_q;
   logic [n_pins-1:0] pin_s1_q, pin_s2_q, pin_prev_q;
   logic [2:0] tm_s1_q, tm_s2_q;
   logic cmp_s1_q, cmp_s2_q;
   always_ff @(posedge clk_sys) begin
      src_s1_q <= irq_sources;
      src_s2_q <= src_s1_q;
      src_prev_q <= src_s2_q;
      pin_s1_q <= pins_in;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
      tm_s1_q <= timer_match;
      tm_s2_q <= tm_s1_q;
      cmp_s1_q <= comparator_event;
      cmp_s2_q <= cmp_s1_q;
   end

   function automatic logic edge_hit(input logic now, input logic prev, input logic [1:0] sel);
      logic rise;
      logic fall;
      rise = now & ~prev;
      fall = ~now & prev;
      unique case (sel)
         edge_rise: edge_hit = rise;
         edge_fall: edge_hit = fall;
         default: edge_hit = rise | fall;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // request flags
   logic [n_lines-1:0] hit;
   genvar g;
   generate
      for (g = 0; g < n_lines; g++) begin : g_edge
         assign hit[g] = edge_hit(src_s2_q[g], src_prev_q[g], edge_select[2*g +: 2]);
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_flags <= '0;
      end else begin
         // set beats clear; enables do not gate setting
         irq_flags <= ((flag_write ? (irq_flags & flag_write_data) : irq_flags)) | hit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         global_enable <= 1'b0;
      end else if (core.op_valid && core.op == op_take_irq) begin
         global_enable <= 1'b0;
      end else if (state_q == st_pop_wait && op_q == op_reti) begin
         // a register pop shares the wait state but must not re-enable
         global_enable <= 1'b1;
      end else if (global_enable_op) begin
         global_enable <= 1'b1;
      end else if (global_disable_op) begin
         global_enable <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         core.irq_pending <= 1'b0;
      end else begin
         core.irq_pending <= global_enable && |(irq_flags & irq_line_enables);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stack sequencing; pc and work/flag pair each take one two-byte slot
   logic [2:0] op_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stack_pointer <= 8'h00;
         stack_we <= 1'b0;
         stack_addr <= 8'h00;
         stack_wdata <= 16'h0000;
         op_q <= op_none;
      end else begin
         stack_we <= 1'b0;
         if (stack_pointer_write) begin
            stack_pointer <= stack_pointer_wdata; // bit 0 kept clear by software
         end else if (core.op_valid && state_q == st_run) begin
            op_q <= core.op;
            unique case (core.op)
               op_take_irq, op_push: begin
                  stack_we <= 1'b1;
                  stack_addr <= stack_pointer;
                  stack_wdata <= (core.op == op_push) ? {core.work_register, core.flags}
                                                      : core.pc;
                  stack_pointer <= stack_pointer + slot_bytes;
               end
               op_reti, op_pop: begin
                  stack_addr <= stack_pointer - slot_bytes;
                  stack_pointer <= stack_pointer - slot_bytes;
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         core.op_done <= 1'b0;
         core.next_pc <= 16'h0000;
         core.work_restore <= 8'h00;
         core.flags_restore <= 8'h00;
      end else begin
         core.op_done <= 1'b0;
         if (core.op_valid && state_q == st_run && core.op == op_take_irq) begin
            core.op_done <= 1'b1;
            core.next_pc <= vector_addr;
         end else if (core.op_valid && state_q == st_run && core.op == op_push) begin
            core.op_done <= 1'b1;
         end else if (state_q == st_pop_wait) begin
            core.op_done <= 1'b1;
            if (op_q == op_reti) begin
               core.next_pc <= stack_rdata;
            end else begin
               {core.work_restore, core.flags_restore} <= stack_rdata;
            end
         end else if (state_q == st_waking && wake_done) begin
            core.op_done <= 1'b1;
            core.next_pc <= core.pc;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sleep and wake
   logic pin_toggle_light, pin_toggle_deep, light_wake, deep_wake, fast_sel;
   assign pin_toggle_light = |((pin_s2_q ^ pin_prev_q) & pin_direction & pin_digital_enable);
   assign pin_toggle_deep = |((pin_s2_q ^ pin_prev_q) & pin_digital_enable);
   assign light_wake = pin_toggle_light || |(tm_s2_q & timer_off_system_clock)
      || (cmp_s2_q && comparator_control[cmp_enable_bit]
          && comparator_select[cmp_wake_bit]);
   assign deep_wake = pin_toggle_deep;
   assign fast_sel = fast_boot || system_option[fast_wake_bit];

   wake_timer u_wake (
      .clk_sys(clk_sys),
      .reset(reset),
      .start((state_q == st_light && light_wake) || (state_q == st_deep && deep_wake)),
      .fast(fast_sel),
      .osc_tick(slow_osc_tick),
      .done(wake_done)
   );

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= st_run;
      end else begin
         unique case (state_q)
            st_run: begin
               if (core.op_valid && (core.op == op_reti || core.op == op_pop)) begin
                  state_q <= st_pop_wait;
               end else if (core.op_valid && core.op == op_light_sleep) begin
                  state_q <= st_light;
               end else if (core.op_valid && core.op == op_deep_sleep) begin
                  state_q <= st_deep;
               end
            end
            st_pop_wait: state_q <= st_run;
            st_light: if (light_wake) state_q <= st_waking;
            st_deep: if (deep_wake) state_q <= st_waking;
            st_waking: if (wake_done) state_q <= st_run;
         endcase
      end
   end

   // deep sleep stops oscillators; the slow one must still tick out the wake delay,
   // so it restarts as soon as the waking period begins
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         system_clock_en <= 1'b1;
         fast_internal_osc_en <= 1'b1;
         slow_internal_osc_en <= 1'b1;
         crystal_osc_en <= 1'b0;
         program_mem_on <= 1'b1;
         system_clock_timer_run <= 1'b1;
         run_on_slow_osc <= 1'b0;
         core.cpu_halted <= 1'b0;
      end else begin
         system_clock_en <= (state_q == st_run || state_q == st_pop_wait);
         core.cpu_halted <= !(state_q == st_run || state_q == st_pop_wait);
         program_mem_on <= (state_q == st_run || state_q == st_pop_wait);
         system_clock_timer_run <= (state_q == st_run || state_q == st_pop_wait);
         slow_internal_osc_en <= (state_q != st_deep);
         if (state_q == st_deep) begin
            fast_internal_osc_en <= 1'b0;
            crystal_osc_en <= 1'b0;
         end else if (state_q == st_run) begin
            // nothing else turns it back on, so it returns once the wake delay is over
            fast_internal_osc_en <= 1'b1;
         end
         if (state_q == st_waking) begin
            run_on_slow_osc <= 1'b1;
         end else if (state_q == st_run && core.op_valid) begin
            run_on_slow_osc <= 1'b0;
         end
      end
   end
endmodule // irq_sleep_ctrl

/* File: src/irq_sleep_if.sv */
// carrier between the controller (device end) and the core-side end
interface irq_sleep_if;
   import irq_sleep_pkg::*;
   logic [2:0] op;
   logic op_valid;
   logic [15:0] pc;
   logic [7:0] work_register;
   logic [7:0] flags;
   logic op_done;
   logic [15:0] next_pc;
   logic [7:0] work_restore;
   logic [7:0] flags_restore;
   logic irq_pending;
   logic cpu_halted;
   modport device (input op, op_valid, pc, work_register, flags,
      output op_done, next_pc, work_restore, flags_restore, irq_pending, cpu_halted);
   modport core (output op, op_valid, pc, work_register, flags,
      input op_done, next_pc, work_restore, flags_restore, irq_pending, cpu_halted);
endinterface

/* File: src/irq_sleep_pkg.sv */
// constants shared by the interrupt/sleep controller and its core-side partner
// assumes one 250 MHz system clock; the slow oscillator arrives as a one-cycle tick
// What this block does
// - eight request lines, two pins plus six peripherals
// - per-line enables; hardware sets flags, software clears
// - flag sets on rising, falling or both edges
// - global enable permits, global disable blocks servicing
// - flags still set while line enable is zero
// - entry pushes pc, sp+2, clears global enable
// - return pops pc, sp-2, sets global enable
// - software keeps stack pointer bit zero clear
// - push/pop save and restore work and flag registers
// - software reserves two bytes per nesting level
// - light sleep gates only the system clock
// - deep sleep stops every oscillator, state kept
// - program memory off in both sleep modes
// - light sleep timers stop unless clocked elsewhere
// - slow oscillator stays on except in deep sleep; wake runs on it
// - light sleep wakes on enabled digital input toggle
// - light sleep wakes on non-system-clock timer match
// - comparator wakes light sleep if enable and wake
// - deep sleep wakes only on digital input toggle
// - wake latency 3000 or 45 slow clocks
// - fast boot forces fast wake, else option bit
// - pin wake resumes after sleep instruction, no reset
// - software disables comparator before deep sleep
package irq_sleep_pkg;
   localparam int n_lines = 8;
   localparam int line_ext_a = 0;
   localparam int line_ext_b = 1;
   localparam int line_adc = 2;
   localparam int line_timer16 = 3;
   localparam int line_comparator = 4;
   localparam int line_pwm0 = 5;
   localparam int line_timer_a = 6;
   localparam int line_timer_b = 7;
   localparam logic [15:0] vector_addr = 16'h0010;
   localparam logic [7:0] slot_bytes = 8'h02;
   localparam int cmp_enable_bit = 7;
   localparam int cmp_wake_bit = 6;
   localparam int fast_wake_bit = 5;
   localparam int wake_normal_clocks = 3000;
   localparam int wake_fast_clocks = 45;
   localparam int n_pins = 16;
   localparam logic [1:0] edge_rise = 2'h0;
   localparam logic [1:0] edge_fall = 2'h1;
   localparam logic [1:0] edge_both = 2'h2;
   typedef enum logic [2:0] {
      op_none, op_take_irq, op_reti, op_push, op_pop, op_light_sleep, op_deep_sleep
   } core_op_t;
endpackage

/* File: src/wake_timer.sv */
// wake latency counter, steps on slow-oscillator ticks
// assumes osc_tick is a one-cycle pulse on clk_sys
module wake_timer
   import irq_sleep_pkg::*;
#(
   parameter int normal_clocks = wake_normal_clocks,
   parameter int fast_clocks = wake_fast_clocks
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic start,
   input wire logic fast,
   input wire logic osc_tick,
   output logic done
);
   logic [11:0] count_q;
   logic busy_q;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         busy_q <= 1'b0;
         count_q <= 12'h000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            busy_q <= 1'b1;
            count_q <= fast ? 12'(fast_clocks - 1) : 12'(normal_clocks - 1);
         end else if (busy_q && osc_tick) begin
            if (count_q == 12'h000) begin
               busy_q <= 1'b0;
               done <= 1'b1;
            end else begin
               count_q <= count_q - 12'h001;
            end
         end
      end
   end
endmodule // wake_timer
